// ==== core/pch_pkg.sv ====
// shared constants and types for the card signal-control link
package pch_pkg;
	typedef enum logic [1:0] {PCH_MODE_MEM, PCH_MODE_IO, PCH_MODE_IDE} pch_mode_t;
	typedef enum logic [1:0] {PCH_DMA_IDLE, PCH_DMA_REQ, PCH_DMA_XFER} pch_dma_t;
	typedef enum logic [1:0] {PCH_HST_IDLE, PCH_HST_WAIT, PCH_HST_XFER} pch_hst_t;
	localparam int PCH_ADDR_W = 11;
	localparam int PCH_DATA_W = 16;
	localparam int PCH_RA_W = 4;
	// power-up / reset busy time
	localparam int PCH_CLK_MHZ = 250;
	localparam int PCH_INIT_NS = 1000;
	localparam int PCH_INIT_CYC = (PCH_INIT_NS * PCH_CLK_MHZ + 999) / 1000;
	localparam logic [11:0] PCH_INIT_CNT = 12'(PCH_INIT_CYC);
	// configuration option register soft reset bit, config status register enable bit
	localparam int PCH_COR_SRST_BIT = 7;
	localparam int PCH_CSR_CHG_EN_BIT = 6;
	localparam logic [PCH_ADDR_W-1:0] PCH_COR_ADDR = 11'h200;
	localparam logic [PCH_ADDR_W-1:0] PCH_CSR_ADDR = 11'h202;
	// 16-bit capable port window in I/O mode
	localparam logic [PCH_ADDR_W-1:0] PCH_IO16_ADDR = 11'h000;
	// host register offsets
	localparam logic [PCH_RA_W-1:0] PCH_R_CTRL = 4'h0;
	localparam logic [PCH_RA_W-1:0] PCH_R_STAT = 4'h1;
	localparam logic [PCH_RA_W-1:0] PCH_R_GEOM_C = 4'h2;
	localparam logic [PCH_RA_W-1:0] PCH_R_GEOM_HS = 4'h3;
	localparam logic [PCH_RA_W-1:0] PCH_R_DATA = 4'h4;
	localparam logic [PCH_RA_W-1:0] PCH_R_ADDR = 4'h5;
	localparam logic [PCH_RA_W-1:0] PCH_R_CYC = 4'h6;
	// single socket cycle kinds: config write, I/O read, common-memory select
	localparam int PCH_CYC_CFG_WR = 0;
	localparam int PCH_CYC_IO_RD = 1;
	localparam int PCH_CYC_COMMON = 2;
	// strobe width in clocks; must outlast the card's two-flop sync and output register
	localparam logic [3:0] PCH_STRB_CNT = 4'h8;
	localparam int PCH_CTRL_RST = 0;
	localparam int PCH_CTRL_IDE = 1;
	localparam int PCH_CTRL_CSEL = 2;
	localparam int PCH_CTRL_DMA_RD = 3;
	localparam int PCH_CTRL_DMA_WR = 4;
	// default geometry per capacity index
	localparam int PCH_CAP_N = 10;
	localparam logic [15:0] PCH_CYL [PCH_CAP_N] = '{16'h03D4, 16'h03D4, 16'h03E1, 16'h07C2, 16'h0F82,
		16'h1F1C, 16'h2736, 16'h2F0E, 16'h36E6, 16'h3EBE};
	localparam logic [7:0] PCH_HEADS [PCH_CAP_N] = '{8'h08, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10,
		8'h10, 8'h10};
	localparam logic [7:0] PCH_SECT [PCH_CAP_N] = '{8'h20, 8'h20, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F,
		8'h3F, 8'h3F};
endpackage

// ==== core/pch_link_if.sv ====
// socket/cable signals between host and card
`timescale 1ns/10ps
interface pch_link_if;
	import pch_pkg::*;
	logic [PCH_ADDR_W-1:0] addr;
	logic [PCH_DATA_W-1:0] wdata;
	logic [PCH_DATA_W-1:0] rdata;
	logic ce1_n;
	logic oe_n;
	logic we_n;
	logic iord_n;
	logic iowr_n;
	logic reg_n;
	logic reset_pin;
	logic csel_n;
	logic dmack_n;
	logic dmarq;
	logic inpack_n;
	logic iois16_n;
	logic wp;
	logic rdy_bsy;
	logic bvd1;
	logic stschg_n;
	logic wait_oe;
	logic pdiag_out;
	logic pdiag_oe;
	logic pdiag_in;
	modport card (input addr, wdata, ce1_n, oe_n, we_n, iord_n, iowr_n, reg_n, reset_pin, csel_n, dmack_n,
		pdiag_in, output rdata, dmarq, inpack_n, iois16_n, wp, rdy_bsy, bvd1, stschg_n, wait_oe, pdiag_out,
		pdiag_oe);
	modport host (output addr, wdata, ce1_n, oe_n, we_n, iord_n, iowr_n, reg_n, reset_pin, csel_n, dmack_n,
		pdiag_in, input rdata, dmarq, inpack_n, iois16_n, wp, rdy_bsy, bvd1, stschg_n, wait_oe, pdiag_out,
		pdiag_oe);
endinterface

// ==== core/pch_card.sv ====
// card end: mode strap, select decode, DMA request, status pins, resets
// How it works
// - IDE: csel low master, high slave
// - memory: reg high common, low attribute
// - host holds reg low in I/O cycles
// - host acks DMA only after request
// - request DMA; direction from strobe; ack handshake
// - PIO-only build leaves DMA pins unused
// - memory: write protect low after init
// - I/O: iois16 low on 16-bit port
// - I/O: inpack on selected I/O read
// - memory: battery status held high
// - I/O: status change only when enabled
// - IDE: pdiag two-way diagnostic line
// - never drive wait or iordy
// - PC Card: reset pin high resets
// - soft reset bit causes reset
// - IDE: reset pin active low
// - fixed default geometry by capacity
// - host grounds oe to select IDE
// - busy until init done; host waits
`timescale 1ns/10ps
module pch_card #(
	parameter bit PIO_ONLY = 1'b0,
	parameter int CAP_IDX = 3
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// socket
	pch_link_if.card lnk,
	// user side
	input wire logic data_ready,
	input wire logic [PCH_DATA_W-1:0] port_rdata,
	output logic dev_busy,
	output logic ide_mode,
	output logic slave_role,
	output logic attr_sel,
	output logic [15:0] geom_cyl,
	output logic [7:0] geom_heads,
	output logic [7:0] geom_sect
);
	import pch_pkg::*;
	// every socket input the card uses crosses two flops; pdiag_in is unused
	logic [7:0] s1, s2;
	logic [PCH_ADDR_W-1:0] a1, a2;
	logic [PCH_DATA_W-1:0] d1, d2;
	pch_mode_t mode;
	pch_dma_t dma;
	logic [11:0] init_cnt;
	logic strap_done, srst, pin_rst, pin_lvl_prev, wp_prev, busy_prev, chg_en;
	wire ce_n = s2[0], oe_n = s2[1], we_n = s2[2], iord_n = s2[3];
	wire iowr_n = s2[4], reg_n = s2[5], rst_pin = s2[6], dmack_n = s2[7];
	wire dma_ok = !PIO_ONLY;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s1 <= 8'hFF;
			s2 <= 8'hFF;
			a1 <= '0;
			a2 <= '0;
			d1 <= '0;
			d2 <= '0;
		end else if (clk_en) begin
			s1 <= {lnk.dmack_n, lnk.reset_pin, lnk.reg_n, lnk.iowr_n, lnk.iord_n, lnk.we_n, lnk.oe_n, lnk.ce1_n};
			s2 <= s1;
			a1 <= lnk.addr;
			a2 <= a1;
			d1 <= lnk.wdata;
			d2 <= d1;
		end
	end

	// strap mode and role once after release; held until next nrst, except memory mode moves to I/O once the status-change enable is set
	logic csel1, csel2, sv1, sv2;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			csel1 <= 1'b0;
			csel2 <= 1'b0;
			sv1 <= 1'b0;
			sv2 <= 1'b0;
			strap_done <= 1'b0;
			mode <= PCH_MODE_MEM;
			slave_role <= 1'b0;
			ide_mode <= 1'b0;
		end else if (clk_en) begin
			csel1 <= lnk.csel_n;
			csel2 <= csel1;
			sv1 <= 1'b1;
			sv2 <= sv1;
			// wait until both sync stages hold pin samples, not their reset values
			if (!strap_done && sv2 && s2 == s1) begin
				strap_done <= 1'b1;
				mode <= oe_n ? PCH_MODE_MEM : PCH_MODE_IDE;
				ide_mode <= !oe_n;
				slave_role <= !oe_n && csel2;
			end else if (strap_done && mode == PCH_MODE_MEM && chg_en) begin
				mode <= PCH_MODE_IO;
			end
		end
	end

	// hardware reset: high in PC Card modes, low in IDE; held-high from power-up ignored
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pin_lvl_prev <= 1'b1;
		end else if (clk_en) begin
			pin_lvl_prev <= rst_pin;
		end
	end
	assign pin_rst = (mode == PCH_MODE_IDE) ? !rst_pin : (rst_pin && !pin_lvl_prev);

	// configuration writes: soft reset and status-change enable
	logic we_prev;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			we_prev <= 1'b1;
			srst <= 1'b0;
			chg_en <= 1'b0;
		end else if (clk_en) begin
			we_prev <= we_n;
			srst <= 1'b0;
			// soft reset keeps the enable so the busy edge it causes is still reported
			if (pin_rst) begin
				chg_en <= 1'b0;
			end else if (mode != PCH_MODE_IDE && !ce_n && !reg_n && we_n && !we_prev) begin
				if (a2 == PCH_COR_ADDR && d2[PCH_COR_SRST_BIT]) begin
					srst <= 1'b1;
				end
				if (a2 == PCH_CSR_ADDR) begin
					chg_en <= d2[PCH_CSR_CHG_EN_BIT];
				end
			end
		end
	end

	// init busy interval after power-up or any reset
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			init_cnt <= PCH_INIT_CNT;
		end else if (clk_en) begin
			if (pin_rst || srst) begin
				init_cnt <= PCH_INIT_CNT;
			end else if (init_cnt != '0) begin
				init_cnt <= init_cnt - 12'h001;
			end
		end
	end

	// DMA request/acknowledge
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dma <= PCH_DMA_IDLE;
		end else if (clk_en) begin
			case (dma)
				PCH_DMA_IDLE: if (dma_ok && mode == PCH_MODE_IDE && init_cnt == '0 && data_ready) begin
					dma <= PCH_DMA_REQ;
				end
				PCH_DMA_REQ: if (!dmack_n) begin
					dma <= PCH_DMA_XFER;
				end
				PCH_DMA_XFER: if (dmack_n) begin
					dma <= PCH_DMA_IDLE;
				end
				default: dma <= PCH_DMA_IDLE;
			endcase
			if (pin_rst || srst) begin
				dma <= PCH_DMA_IDLE;
			end
		end
	end

	// socket outputs, all registered
	wire io_rd = mode == PCH_MODE_IO && !ce_n && !reg_n && !iord_n;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			lnk.dmarq <= 1'b0;
			lnk.inpack_n <= 1'b1;
			lnk.iois16_n <= 1'b1;
			lnk.wp <= 1'b1;
			lnk.rdy_bsy <= 1'b0;
			lnk.bvd1 <= 1'b1;
			lnk.stschg_n <= 1'b1;
			lnk.rdata <= '0;
			wp_prev <= 1'b1;
			busy_prev <= 1'b0;
			dev_busy <= 1'b1;
			attr_sel <= 1'b0;
		end else if (clk_en) begin
			lnk.dmarq <= dma_ok && (dma == PCH_DMA_REQ || (dma == PCH_DMA_XFER && data_ready));
			lnk.inpack_n <= !io_rd;
			lnk.iois16_n <= !(mode == PCH_MODE_IO && !ce_n && a2 == PCH_IO16_ADDR);
			lnk.wp <= (mode == PCH_MODE_MEM) ? (init_cnt != '0) : 1'b0;
			lnk.rdy_bsy <= (init_cnt == '0);
			lnk.bvd1 <= (mode == PCH_MODE_IO) ? lnk.stschg_n : 1'b1;
			wp_prev <= lnk.wp;
			busy_prev <= lnk.rdy_bsy;
			// pulse on a ready/busy or protect change, gated by enable
			lnk.stschg_n <= !(mode == PCH_MODE_IO && chg_en && (wp_prev != lnk.wp || busy_prev != lnk.rdy_bsy));
			if (!iord_n && !ce_n) begin
				lnk.rdata <= port_rdata;
			end
			dev_busy <= (init_cnt != '0);
			attr_sel <= mode == PCH_MODE_MEM && !ce_n && !reg_n;
		end
	end

	// pdiag: slave drives pass-diagnostic low once ready
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			lnk.pdiag_out <= 1'b1;
			lnk.pdiag_oe <= 1'b0;
			lnk.wait_oe <= 1'b0;
		end else if (clk_en) begin
			lnk.pdiag_out <= 1'b0;
			lnk.pdiag_oe <= mode == PCH_MODE_IDE && slave_role && init_cnt == '0;
			lnk.wait_oe <= 1'b0;
		end
	end

	// fixed geometry
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			geom_cyl <= '0;
			geom_heads <= '0;
			geom_sect <= '0;
		end else if (clk_en) begin
			geom_cyl <= PCH_CYL[CAP_IDX];
			geom_heads <= PCH_HEADS[CAP_IDX];
			geom_sect <= PCH_SECT[CAP_IDX];
		end
	end
endmodule

// ==== core/pch_host.sv ====
// host end: pin drive from software registers, DMA acknowledge
`timescale 1ns/10ps
module pch_host (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// software port
	input wire logic [pch_pkg::PCH_RA_W-1:0] sw_addr,
	input wire logic [15:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [15:0] sw_rdata,
	// socket
	pch_link_if.host lnk
);
	import pch_pkg::*;
	pch_hst_t st;
	logic [4:0] ctrl;
	logic rq1, rq2, rb1, rb2, pd1, pd2;
	logic [15:0] dword;
	logic [2:0] kind;
	logic [3:0] cnt;
	logic pend;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rq1 <= 1'b0;
			rq2 <= 1'b0;
			rb1 <= 1'b0;
			rb2 <= 1'b0;
			pd1 <= 1'b1;
			pd2 <= 1'b1;
		end else if (clk_en) begin
			rq1 <= lnk.dmarq;
			rq2 <= rq1;
			rb1 <= lnk.rdy_bsy;
			rb2 <= rb1;
			pd1 <= !(lnk.pdiag_oe && !lnk.pdiag_out);
			pd2 <= pd1;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= 5'h01;
		end else if (clk_en && sw_wr && sw_addr == PCH_R_CTRL) begin
			ctrl <= sw_wdata[4:0];
		end
	end

	// one strobe engine for DMA and single socket cycles; ack only after request
	// strobes stand long enough for the card's synced, registered read data
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st <= PCH_HST_IDLE;
			lnk.dmack_n <= 1'b1;
			lnk.iord_n <= 1'b1;
			lnk.iowr_n <= 1'b1;
			lnk.we_n <= 1'b1;
			lnk.reg_n <= 1'b0;
			cnt <= '0;
			pend <= 1'b0;
			kind <= '0;
			dword <= '0;
		end else if (clk_en) begin
			case (st)
				PCH_HST_IDLE: if (pend) begin
					pend <= 1'b0;
					lnk.we_n <= !kind[PCH_CYC_CFG_WR];
					lnk.iord_n <= !kind[PCH_CYC_IO_RD];
					lnk.reg_n <= kind[PCH_CYC_COMMON];
					cnt <= PCH_STRB_CNT;
					st <= PCH_HST_XFER;
				end else if (rq2 && (ctrl[PCH_CTRL_DMA_RD] || ctrl[PCH_CTRL_DMA_WR])) begin
					lnk.dmack_n <= 1'b0;
					st <= PCH_HST_WAIT;
				end
				PCH_HST_WAIT: begin
					lnk.iord_n <= !ctrl[PCH_CTRL_DMA_RD];
					lnk.iowr_n <= ctrl[PCH_CTRL_DMA_RD] || !ctrl[PCH_CTRL_DMA_WR];
					cnt <= PCH_STRB_CNT;
					st <= PCH_HST_XFER;
				end
				PCH_HST_XFER: if (cnt != '0) begin
					cnt <= cnt - 4'h1;
				end else begin
					if (!lnk.iord_n) begin
						dword <= lnk.rdata;
					end
					lnk.iord_n <= 1'b1;
					lnk.iowr_n <= 1'b1;
					lnk.we_n <= 1'b1;
					lnk.reg_n <= 1'b0;
					lnk.dmack_n <= 1'b1;
					st <= PCH_HST_IDLE;
				end
				default: st <= PCH_HST_IDLE;
			endcase
			if (sw_wr && sw_addr == PCH_R_CYC) begin
				pend <= 1'b1;
				kind <= sw_wdata[2:0];
			end
		end
	end

	// static pins: IDE mode strap, role strap, reset, card enable held low
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			lnk.reset_pin <= 1'b0;
			lnk.oe_n <= 1'b1;
			lnk.csel_n <= 1'b0;
			lnk.ce1_n <= 1'b0;
			lnk.addr <= '0;
			lnk.wdata <= '0;
			lnk.pdiag_in <= 1'b1;
			sw_rdata <= '0;
		end else if (clk_en) begin
			lnk.reset_pin <= ctrl[PCH_CTRL_IDE] ? !ctrl[PCH_CTRL_RST] : ctrl[PCH_CTRL_RST];
			lnk.oe_n <= !ctrl[PCH_CTRL_IDE];
			lnk.csel_n <= ctrl[PCH_CTRL_CSEL];
			lnk.pdiag_in <= pd2;
			if (sw_wr && sw_addr == PCH_R_DATA) begin
				lnk.wdata <= sw_wdata;
			end
			if (sw_wr && sw_addr == PCH_R_ADDR) begin
				lnk.addr <= sw_wdata[PCH_ADDR_W-1:0];
			end
			sw_rdata <= '0;
			if (sw_rd) begin
				case (sw_addr)
					PCH_R_CTRL: sw_rdata <= {11'h000, ctrl};
					PCH_R_STAT: sw_rdata <= {12'h000, pd2, rq2, rb2, lnk.dmack_n};
					PCH_R_DATA: sw_rdata <= dword;
					default: sw_rdata <= '0;
				endcase
			end
		end
	end
endmodule

// ==== bench/pch_link_asserts.sv ====
// concurrent checks on the host/card socket link
`timescale 1ns/10ps
module pch_link_asserts
	import pch_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// link
	input wire logic oe_n,
	input wire logic iord_n,
	input wire logic dmack_n,
	input wire logic dmarq,
	input wire logic inpack_n,
	input wire logic wp,
	input wire logic rdy_bsy,
	input wire logic bvd1,
	input wire logic stschg_n,
	input wire logic wait_oe,
	input wire logic pdiag_out,
	input wire logic pdiag_oe
);
	int cyc;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// saturates so a later pin reset never wraps it
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			cyc <= 0;
		else if (cyc < 1000)
			cyc <= cyc + 1;
	end
	AST_WAIT_FLOATS: assert property (!wait_oe) else $error("wait line driven");
	AST_ACK_AFTER_REQ: assert property ($fell(dmack_n) |-> $past(dmarq, 2)) else $error("ack without request");
	AST_WP_LOW: assert property (rdy_bsy && $past(rdy_bsy) && oe_n |-> !wp) else $error("wp high when ready");
	// in I/O mode the pin carries the status-change pulse one cycle later
	AST_BVD1_HIGH: assert property (oe_n && $past(stschg_n) |-> bvd1) else $error("bvd1 low outside ide");
	AST_INIT_BUSY: assert property (rdy_bsy |-> cyc >= PCH_INIT_CYC - 3) else $error("ready too early");
	AST_NO_DMA_PC: assert property (oe_n |-> !dmarq) else $error("dma request outside ide");
	AST_INPACK_CAUSE: assert property ($fell(inpack_n) |-> !$past(iord_n, 3)) else $error("inpack without read");
	AST_PDIAG_LOW: assert property (pdiag_oe |-> !pdiag_out) else $error("pdiag driven high");
	AST_STSCHG_PULSE: assert property ($fell(stschg_n) |=> stschg_n) else $error("status change too long");
	COV_DMARQ: cover property ($rose(dmarq));
	COV_ACK: cover property ($fell(dmack_n));
	COV_READY: cover property ($rose(rdy_bsy));
	COV_STSCHG: cover property ($fell(stschg_n));
endmodule

// ==== bench/pc_card_ide_host_signal_control_test.sv ====
// testbench: host and card ends joined over the socket link
`timescale 1ns/10ps
module pc_card_ide_host_signal_control_test;
	import pch_pkg::*;
	logic ref_clk = 1'b0;
	logic card_nrst = 1'b0;
	logic host_nrst = 1'b0;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	logic data_ready = 1'b0;
	logic [3:0] sw_addr = 4'h0;
	logic [15:0] sw_wdata = 16'h0000;
	logic [15:0] port_rdata = 16'hA55A;
	logic [15:0] sw_rdata, geom_cyl, v;
	logic [7:0] geom_heads, geom_sect;
	logic dev_busy, ide_mode, slave_role, attr_sel;
	int miscompares = 0;
	int cmp_count = 0;
	always #2 ref_clk = ~ref_clk;
	pch_link_if lnk();
	// separate resets so the host keeps its strap settings across card resets
	pch_card #(.PIO_ONLY(1'b0), .CAP_IDX(9)) pch_card_i(.ref_clk, .nrst(card_nrst), .clk_en(1'b1), .lnk(lnk.card),
		.data_ready, .port_rdata, .dev_busy, .ide_mode, .slave_role, .attr_sel, .geom_cyl, .geom_heads, .geom_sect);
	pch_host pch_host_i(.ref_clk, .nrst(host_nrst), .clk_en(1'b1), .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata,
		.lnk(lnk.host));
	pch_link_asserts pch_link_asserts_i(.ref_clk, .nrst(card_nrst), .oe_n(lnk.oe_n), .iord_n(lnk.iord_n),
		.dmack_n(lnk.dmack_n), .dmarq(lnk.dmarq), .inpack_n(lnk.inpack_n), .wp(lnk.wp), .rdy_bsy(lnk.rdy_bsy),
		.bvd1(lnk.bvd1), .stschg_n(lnk.stschg_n), .wait_oe(lnk.wait_oe), .pdiag_out(lnk.pdiag_out),
		.pdiag_oe(lnk.pdiag_oe));
	task results;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task bound(input int n, input int lim);
		if (n >= lim) begin
			miscompares++;
			$display("mismatch at %0t: wait ran out, got %h expected %h", $time, n, lim);
			results();
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge ref_clk);
		sw_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge ref_clk);
		sw_rd <= 1'b0;
		#1 d = sw_rdata;
	endtask
	// busy must still stand well inside the init time, then clear in bounded time
	task wait_ready;
		int n;
		repeat (200) @(posedge ref_clk);
		chk(dev_busy, 1'b1);
		for (n = 0; n < 150 && dev_busy !== 1'b0; n++)
			@(posedge ref_clk);
		bound(n, 150);
	endtask
	task t_modes;
		logic [15:0] ctl [3] = '{16'h0004, 16'h0006, 16'h0002};
		int n;
		for (int i = 0; i < 3; i++) begin
			wr(PCH_R_CTRL, ctl[i]);
			repeat (4) @(posedge ref_clk);
			card_nrst <= 1'b0;
			repeat (4) @(posedge ref_clk);
			card_nrst <= 1'b1;
			wait_ready();
			chk(ide_mode, ctl[i][1]);
			chk(slave_role, ctl[i][1] & ctl[i][2]);
			chk(geom_cyl, 16'h3EBE);
			chk(geom_heads, 8'h10);
			chk(geom_sect, 8'h3F);
			rd(PCH_R_STAT, v);
			chk(v[3], !(ctl[i][1] & ctl[i][2]));
			chk(v[1], 1'b1);
			if (!ctl[i][1]) begin
				@(posedge ref_clk);
				chk(lnk.rdy_bsy, 1'b1);
				chk(lnk.wp, 1'b0);
				chk(lnk.bvd1, 1'b1);
			end
			// reset pin: high in card modes, low in ide, host maps bit 0
			wr(PCH_R_CTRL, ctl[i] | 16'h0001);
			for (n = 0; n < 20 && dev_busy !== 1'b1; n++)
				@(posedge ref_clk);
			bound(n, 20);
			wr(PCH_R_CTRL, ctl[i]);
			for (n = 0; n < 400 && dev_busy !== 1'b0; n++)
				@(posedge ref_clk);
			bound(n, 400);
			chk(ide_mode, ctl[i][1]);
			chk(lnk.wait_oe, 1'b0);
			$display("modes step %0d done", i);
		end
	endtask
	task t_dma;
		int n;
		wr(PCH_R_CTRL, 16'h000A);
		data_ready <= 1'b1;
		for (n = 0; n < 50 && lnk.dmack_n !== 1'b0; n++)
			@(posedge ref_clk);
		bound(n, 50);
		chk(lnk.dmarq, 1'b1);
		data_ready <= 1'b0;
		for (n = 0; n < 50 && (lnk.dmarq !== 1'b0 || lnk.dmack_n !== 1'b1); n++)
			@(posedge ref_clk);
		bound(n, 50);
		rd(PCH_R_DATA, v);
		chk(v, 16'hA55A);
		rd(PCH_R_STAT, v);
		chk({v[2], v[0]}, 2'b01);
		$display("dma test done");
	endtask
	// PC Card side: common select, config write to I/O mode, I/O read, soft reset
	task t_io;
		int n;
		wr(PCH_R_CTRL, 16'h0000);
		card_nrst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		card_nrst <= 1'b1;
		wait_ready();
		chk(attr_sel, 1'b1);
		wr(PCH_R_CYC, 16'h0004);
		for (n = 0; n < 20 && attr_sel !== 1'b0; n++)
			@(posedge ref_clk);
		bound(n, 20);
		repeat (20) @(posedge ref_clk);
		wr(PCH_R_ADDR, {5'h00, PCH_CSR_ADDR});
		wr(PCH_R_DATA, 16'h0040);
		wr(PCH_R_CYC, 16'h0001);
		repeat (20) @(posedge ref_clk);
		wr(PCH_R_ADDR, 16'h0000);
		for (n = 0; n < 20 && lnk.iois16_n !== 1'b0; n++)
			@(posedge ref_clk);
		bound(n, 20);
		wr(PCH_R_CYC, 16'h0002);
		for (n = 0; n < 20 && lnk.inpack_n !== 1'b0; n++)
			@(posedge ref_clk);
		bound(n, 20);
		chk(lnk.rdata, 16'hA55A);
		repeat (20) @(posedge ref_clk);
		rd(PCH_R_DATA, v);
		chk(v, 16'hA55A);
		wr(PCH_R_ADDR, {5'h00, PCH_COR_ADDR});
		wr(PCH_R_DATA, 16'h0080);
		wr(PCH_R_CYC, 16'h0001);
		for (n = 0; n < 40 && lnk.stschg_n !== 1'b0; n++)
			@(posedge ref_clk);
		bound(n, 40);
		chk(dev_busy, 1'b1);
		for (n = 0; n < 400 && dev_busy !== 1'b0; n++)
			@(posedge ref_clk);
		bound(n, 400);
		$display("io test done");
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		host_nrst <= 1'b1;
		t_modes();
		t_dma();
		t_io();
		results();
	end
endmodule
